/* File: verilog/p8t_pkg.sv */
// p8t_pkg: register map, field positions, reset values and counts
// assumes a 32-bit axi4-lite slave with word-indexed register slots
package p8t_pkg;

  localparam int          ADDR_W      = 12;
  localparam int          IDX_W       = 10;
  // printed offsets are slot indices; byte address is index times four
  localparam logic [9:0]  IDX_INTCTL  = 10'h00b;
  localparam logic [9:0]  IDX_FLAGS   = 10'h00c;
  localparam logic [9:0]  IDX_COUNT   = 10'h011;
  localparam logic [9:0]  IDX_CTRL    = 10'h012;
  localparam logic [9:0]  IDX_ENABLES = 10'h08c;
  localparam logic [9:0]  IDX_PERIOD  = 10'h092;

  // control field positions
  localparam int          PRE_LSB     = 0;
  localparam int          PRE_MSB     = 1;
  localparam int          RUN_BIT     = 2;
  localparam int          POST_LSB    = 3;
  localparam int          POST_MSB    = 6;
  localparam int          CTRL_W      = 7;
  // flag, enable and interrupt-control bits
  localparam int          MATCH_BIT   = 1;
  localparam int          PERIPHERAL_IRQ_ENABLE_BIT    = 6;
  localparam int          GIE_BIT     = 7;

  localparam logic [7:0]  COUNT_RST   = 8'h00;
  localparam logic [6:0]  CTRL_RST    = 7'h00;
  localparam logic [7:0]  PERIOD_RST  = 8'hff;

  // instruction clock is the oscillator over four
  localparam int          INSTR_DIV   = 4;
  localparam logic [1:0]  INSTR_LAST  = 2'(INSTR_DIV - 1);
  // input divider terminal counts: 1:1, 1:4, 1:16
  localparam logic [3:0]  PRE1_LAST   = 4'h0;
  localparam logic [3:0]  PRE4_LAST   = 4'h3;
  localparam logic [3:0]  PRE16_LAST  = 4'hf;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* File: verilog/p8t_divider.sv */
// p8t_divider: modulo counter giving one tick out per term+1 ticks in
// assumes tick_in and clr are already qualified by the clock enable
`timescale 1ns/1ps
module p8t_divider #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] term,
  output logic              tick_out
);
  logic [W-1:0] cnt_r;

  // clear takes precedence so a tick in the clear cycle is dropped
  assign tick_out = tick_in && !clr && (cnt_r == term);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (clr) begin
        cnt_r <= '0;
      end else if (tick_in) begin
        // >= so a term lowered below the count still wraps
        cnt_r <= (cnt_r >= term) ? '0 : cnt_r + W'(1);
      end
    end
  end

endmodule // p8t_divider

/* File: verilog/p8t_timer.sv */
// p8t_timer: 8-bit period timer with input and output dividers
// assumes aclk is the oscillator, axi4-lite master on the same clock
//
// Operation
// - count climbs from zero; tick after equalling period returns it to zero
// - count clocked by instruction clock (oscillator/4) through the input divider
// - control bits 1:0 pick input divide 1, 4, or 16 when upper set
// - control bits 6:3 divide period matches by field value plus one
// - each output divider pulse sets the match flag, flag register bit 1
// - count or control writes and any reset clear both dividers
// - control write leaves count value unchanged
// - count readable, writable, zero after reset
// - period readable, writable, all ones after reset
// - undivided match pulse goes to the serial port shift clock
// - undivided match pulse is the pwm period time base
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module p8t_timer (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  input  wire logic [p8t_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [p8t_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic                            irq,
  output logic                            ssp_shift_tick,
  output logic                            pwm_period_tick
);
  import p8t_pkg::*;

  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic [IDX_W-1:0]  aw_idx_r;
  logic [31:0]       wdata_r;
  logic              wlane0_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic [1:0]        phase_r;
  logic [7:0]        count_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [7:0]        period_r;
  logic              flag_r;
  logic              match_ie_r;
  logic              peripheral_irq_enable_r;
  logic              gie_r;
  logic              irq_r;
  logic              ssp_r;
  logic              pwm_r;
  logic              wr_go;
  logic              wr_hit;
  logic              wr_en;
  logic              wr_count;
  logic              wr_ctrl;
  logic              div_clr;
  logic              flag_clr;
  logic              instr_tick;
  logic              cnt_tick;
  logic              match;
  logic              post_pulse;
  logic [3:0]        pre_term;
  logic [IDX_W-1:0]  rd_idx;
  logic [7:0]        rd8;
  logic              rd_hit;

  ////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order

  assign wr_go = ce && !awready_r && !wready_r && !bvalid_r;

  always_comb begin
    if (aw_idx_r == IDX_INTCTL) begin
      wr_hit = 1'b1;
    end else if (aw_idx_r == IDX_FLAGS) begin
      wr_hit = 1'b1;
    end else if (aw_idx_r == IDX_COUNT) begin
      wr_hit = 1'b1;
    end else if (aw_idx_r == IDX_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_idx_r == IDX_ENABLES) begin
      wr_hit = 1'b1;
    end else if (aw_idx_r == IDX_PERIOD) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // registers are 8 bits wide, so only byte lane 0 matters
  assign wr_en    = wr_go && wr_hit && wlane0_r;
  assign wr_count = wr_en && (aw_idx_r == IDX_COUNT);
  assign wr_ctrl  = wr_en && (aw_idx_r == IDX_CTRL);
  assign flag_clr = wr_en && (aw_idx_r == IDX_FLAGS) && wdata_r[MATCH_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_idx_r  <= '0;
      wdata_r   <= '0;
      wlane0_r  <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_r) begin
        aw_idx_r  <= s_axi_awaddr[ADDR_W-1:2];
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r  <= s_axi_wdata;
        wlane0_r <= s_axi_wstrb[0];
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rd8    = 8'h00;
    rd_hit = 1'b1;
    if (rd_idx == IDX_INTCTL) begin
      rd8[GIE_BIT]  = gie_r;
      rd8[PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_r;
    end else if (rd_idx == IDX_FLAGS) begin
      rd8[MATCH_BIT] = flag_r;
    end else if (rd_idx == IDX_COUNT) begin
      rd8 = count_r;
    end else if (rd_idx == IDX_CTRL) begin
      rd8 = {1'b0, ctrl_r};
    end else if (rd_idx == IDX_ENABLES) begin
      rd8[MATCH_BIT] = match_ie_r;
    end else if (rd_idx == IDX_PERIOD) begin
      rd8 = period_r;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end else if (ce) begin
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= {24'h000000, rd8};
        rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timer core

  // instruction clock phase; the phase itself is never cleared by writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= 2'h0;
    end else if (ce) begin
      phase_r <= (phase_r == INSTR_LAST) ? 2'h0 : phase_r + 2'h1;
    end
  end

  assign instr_tick = ce && (phase_r == INSTR_LAST);
  assign div_clr    = wr_count || wr_ctrl;

  always_comb begin
    if (ctrl_r[PRE_MSB]) begin
      pre_term = PRE16_LAST;
    end else if (ctrl_r[PRE_LSB]) begin
      pre_term = PRE4_LAST;
    end else begin
      pre_term = PRE1_LAST;
    end
  end

  p8t_divider #(.W(4)) pre_u (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .clr      (div_clr),
    .tick_in  (instr_tick && ctrl_r[RUN_BIT]),
    .term     (pre_term),
    .tick_out (cnt_tick)
  );

  assign match = cnt_tick && (count_r == period_r);

  p8t_divider #(.W(4)) post_u (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .clr      (div_clr),
    .tick_in  (match),
    .term     (ctrl_r[POST_MSB:POST_LSB]),
    .tick_out (post_pulse)
  );

  // a count write wins over a tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RST;
    end else if (ce) begin
      if (wr_count) begin
        count_r <= wdata_r[7:0];
      end else if (cnt_tick) begin
        count_r <= match ? 8'h00 : count_r + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= CTRL_RST;
      period_r <= PERIOD_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[CTRL_W-1:0];
      end
      if (wr_en && aw_idx_r == IDX_PERIOD) begin
        period_r <= wdata_r[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flag, enables and interrupt

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r     <= 1'b0;
      match_ie_r <= 1'b0;
      peripheral_irq_enable_r     <= 1'b0;
      gie_r      <= 1'b0;
    end else if (ce) begin
      // set beats a write-one-to-clear in the same cycle
      flag_r <= post_pulse || (flag_r && !flag_clr);
      if (wr_en && aw_idx_r == IDX_ENABLES) begin
        match_ie_r <= wdata_r[MATCH_BIT];
      end
      if (wr_en && aw_idx_r == IDX_INTCTL) begin
        gie_r  <= wdata_r[GIE_BIT];
        peripheral_irq_enable_r <= wdata_r[PERIPHERAL_IRQ_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
      ssp_r <= 1'b0;
      pwm_r <= 1'b0;
    end else if (ce) begin
      irq_r <= flag_r && match_ie_r && peripheral_irq_enable_r && gie_r;
      ssp_r <= match;
      pwm_r <= match;
    end
  end

  assign s_axi_awready   = awready_r;
  assign s_axi_wready    = wready_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_arready   = arready_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rresp     = rresp_r;
  assign s_axi_rdata     = rdata_r;
  assign irq             = irq_r;
  assign ssp_shift_tick  = ssp_r;
  assign pwm_period_tick = pwm_r;

  ////////////////////////////////////////////////////////////////////
  // assertions

  count_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (match && !wr_count) |=> count_r == 8'h00)
    else $error("count did not wrap to zero after match");

  count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cnt_tick && !match && !wr_count) |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not step by one");

  instr_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    instr_tick |=> !instr_tick [*3])
    else $error("instruction tick faster than one in four");

  pre_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[RUN_BIT] && ctrl_r[PRE_MSB:PRE_LSB] == 2'b00 && !div_clr)
      |-> cnt_tick == instr_tick)
    else $error("divide-by-one input path wrong");

  post_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[POST_MSB:POST_LSB] == 4'h0 && !div_clr) |-> post_pulse == match)
    else $error("divide-by-one output path wrong");

  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    post_pulse |=> flag_r)
    else $error("match flag not set by output pulse");

  halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_r[RUN_BIT] && !wr_count) |=> count_r == $past(count_r))
    else $error("count moved while halted");

  div_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    div_clr |=> post_u.cnt_r == 4'h0 && pre_u.cnt_r == 4'h0)
    else $error("dividers not cleared by write");

  ctrl_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> count_r == $past(count_r))
    else $error("control write disturbed count");

  reset_val_a: assert property (@(posedge aclk)
    !aresetn |=> count_r == COUNT_RST && period_r == PERIOD_RST)
    else $error("count or period reset value wrong");

  match_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    match |=> ssp_shift_tick && pwm_period_tick)
    else $error("match pulse not offered to serial port and pwm");

  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> irq == $past(flag_r && match_ie_r && peripheral_irq_enable_r && gie_r))
    else $error("interrupt does not follow gated flag");

  ce_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ce |=> count_r == $past(count_r) && flag_r == $past(flag_r))
    else $error("state moved while clock enable low");

  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && flag_r && !flag_clr) |=> flag_r)
    else $error("match flag dropped without clear");

  wrap_c:  cover property (@(posedge aclk) disable iff (!aresetn) match ##1 count_r == 8'h00);
  post_c:  cover property (@(posedge aclk) disable iff (!aresetn)
    post_pulse && ctrl_r[POST_MSB:POST_LSB] != 4'h0);
  irq_c:   cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  wrcnt_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_count && cnt_tick);

endmodule // p8t_timer

/* File: testbench/periodic_8bit_timer_tb_top.sv */
// periodic_8bit_timer_tb_top: self-checking bench for the 8-bit period timer
// assumes p8t_pkg and the design files are compiled first; one clock, ce high except one 30-cycle freeze
`timescale 1ns/1ps
module periodic_8bit_timer_tb_top;
  import p8t_pkg::*;
  localparam int LIMIT = 90000;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        irq, ssp_shift_tick, pwm_period_tick;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] lfsr = 32'hbd4b;
  logic [31:0] d;
  int          posts [3] = '{0, 2, 15};
  logic [9:0]  ridx [6] = '{IDX_INTCTL, IDX_FLAGS, IDX_COUNT, IDX_CTRL, IDX_ENABLES, IDX_PERIOD};
  logic [7:0]  rrst [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};

  p8t_timer dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
    .ssp_shift_tick, .pwm_period_tick
  );

  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t %s: saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // hang guard: a stuck handshake ends the run as a failure
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      report_and_stop();
    end
  end

  // both period outputs are the same undivided match pulse
  always @(posedge aclk) begin
    if (aresetn && (ssp_shift_tick | pwm_period_tick)) begin
      chk(ssp_shift_tick, pwm_period_tick, "ssp and pwm ticks differ");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "write response");
  endtask

  task automatic axi_rd(input logic [9:0] idx, output logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er, "read response");
  endtask

  task automatic check_defaults();
    for (int i = 0; i < 6; i++) begin
      axi_rd(ridx[i], d, RESP_OKAY);
      chk(d, {24'h0, rrst[i]}, "reset value");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int c;
    int div;
    logic [7:0] per;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    check_defaults();
    axi_rd(10'h001, d, RESP_SLVERR);
    axi_wr(10'h001, 8'hff, RESP_SLVERR);
    // software access and halt: count holds still with run clear
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      axi_wr(IDX_PERIOD, lfsr[7:0], RESP_OKAY);
      axi_rd(IDX_PERIOD, d, RESP_OKAY);
      chk(d, {24'h0, lfsr[7:0]}, "period readback");
      axi_wr(IDX_COUNT, lfsr[15:8], RESP_OKAY);
      repeat (20) @(posedge aclk);
      axi_wr(IDX_CTRL, 8'h28, RESP_OKAY);
      axi_rd(IDX_COUNT, d, RESP_OKAY);
      chk(d, {24'h0, lfsr[15:8]}, "count after control write");
    end
    axi_wr(IDX_INTCTL, 8'hc0, RESP_OKAY);
    axi_wr(IDX_ENABLES, 8'h02, RESP_OKAY);
    // every input divider code against a few output divider settings
    for (int pre = 0; pre < 4; pre++) begin
      div = (pre == 0) ? 1 : ((pre == 1) ? 4 : 16);
      for (int j = 0; j < 3; j++) begin
        lfsr = lfsr_next(lfsr);
        per = {5'h0, lfsr[2:0]} + 8'h01;
        axi_wr(IDX_CTRL, 8'h00, RESP_OKAY);
        axi_wr(IDX_PERIOD, per, RESP_OKAY);
        axi_wr(IDX_COUNT, 8'h00, RESP_OKAY);
        axi_wr(IDX_FLAGS, 8'h02, RESP_OKAY);
        axi_wr(IDX_CTRL, {1'b0, 4'(posts[j]), 1'b1, 2'(pre)}, RESP_OKAY);
        n = 0;
        while (irq !== 1'b1) begin
          @(posedge aclk);
          if (pwm_period_tick === 1'b1) n++;
        end
        chk(n, posts[j] + 1, "matches per flag");
        while (pwm_period_tick !== 1'b1) @(posedge aclk);
        c = 0;
        do begin
          @(posedge aclk);
          c++;
        end while (pwm_period_tick !== 1'b1);
        chk(c, 4 * div * (per + 1), "match spacing");
      end
    end
    axi_rd(IDX_FLAGS, d, RESP_OKAY);
    chk(d, 32'h2, "flag set");
    axi_wr(IDX_CTRL, 8'h00, RESP_OKAY);
    n = 0;
    repeat (300) begin
      @(posedge aclk);
      if (pwm_period_tick === 1'b1) n++;
    end
    chk(n, 0, "ticks while halted");
    // irq needs match, peripheral and global enables together
    for (int k = 0; k < 8; k++) begin
      axi_wr(IDX_INTCTL, {k[2], k[1], 6'h0}, RESP_OKAY);
      axi_wr(IDX_ENABLES, {6'h0, k[0], 1'b0}, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(irq, (k == 7), "irq gating");
    end
    axi_wr(IDX_FLAGS, 8'h02, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(irq, 0, "irq after clear");
    axi_rd(IDX_FLAGS, d, RESP_OKAY);
    chk(d, 32'h0, "flag cleared");
    // reset while running returns every register to its default
    axi_wr(IDX_CTRL, 8'h04, RESP_OKAY);
    repeat (40) @(posedge aclk);
    // freeze the running timer with the clock enable
    ce <= 1'b0;
    repeat (30) @(posedge aclk);
    ce <= 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check_defaults();
    report_and_stop();
  end
endmodule // periodic_8bit_timer_tb_top
